/* File: hdl/adc_average_and_correction_pkg.sv */
// constants for the converter averaging, offset, gain and trim block
package adc_average_and_correction_pkg;
    localparam logic [7:0] CONTROL_THREE_OFFSET = 8'h24;
    localparam logic [7:0] OFFSET_CORR_OFFSET   = 8'h28;
    localparam logic [7:0] PLUS_GAIN_OFFSET     = 8'h2C;
    localparam logic [7:0] MINUS_GAIN_OFFSET    = 8'h30;
    localparam logic [7:0] PLUS_TRIM_D_OFFSET   = 8'h34;
    localparam logic [7:0] PLUS_TRIM_S_OFFSET   = 8'h38;
    localparam logic [7:0] PLUS_TRIM_FOUR_OFFSET = 8'h3C;
    localparam logic [7:0] CAL_CONTROL_OFFSET   = 8'h40;

    localparam int CAL_START_BIT   = 7;
    localparam int CONTINUOUS_BIT  = 3;
    localparam int AVERAGE_EN_BIT  = 2;
    localparam int AVG_SEL_LSB     = 0;
    localparam int TRIM_DS_WIDTH   = 6;
    localparam int TRIM_FOUR_WIDTH = 10;
    localparam int GAIN_WIDTH      = 16;
    localparam int RESULT_WIDTH    = 16;

    localparam logic [15:0] GAIN_RESET      = 16'h8000;
    localparam logic [15:0] OFFSET_RESET    = 16'h0000;
    localparam logic [7:0]  CONTROL_RESET   = 8'h00;
    localparam logic [5:0]  TRIM_DS_RESET   = 6'h00;
    localparam logic [9:0]  TRIM_FOUR_RESET = 10'h000;
    localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

    typedef enum logic [1:0] {IDLE, CONVERT, WAIT_RESULT} conv_state_t;

    // averaging count select to log2 of samples: 4,8,16,32
    function automatic logic [2:0] avg_shift(input logic [1:0] sel);
        avg_shift = 3'(sel) + 3'h2;
    endfunction
endpackage

/* File: hdl/adc_average_and_correction.sv */
// averaging, offset, gain and plus-side trim logic of a converter
`timescale 1ns/1ns
// Function
// R1 - continuous enable repeats conversions after initiation
// R2 - single mode: one conversion or set, stop
// R3 - bit 2 switches hardware averaging
// R4 - select picks 4, 8, 16, 32 samples
// R5 - averaged result is mean of samples
// R6 - offset is 16-bit two's complement value
// R7 - offset subtracted from each result
// R8 - corrected result clamped to mode limits
// R9 - plus gain: plus side or whole conversion
// R10 - plus gain unsigned, point below bit 15
// R11 - minus gain only used when differential
// R12 - minus gain 16-bit, point below 15
// R13 - software loads both gains from calibration
// R14 - trims load when calibration finishes
// R15 - calibration start clears when sequence completes
// R16 - trims d, s six bits; four ten
// R17 - software avoids rewriting trims after calibration
// R18 - reserved upper bits read as zero
module adc_average_and_correction
    import adc_average_and_correction_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // register port
    input  wire logic [7:0]  address,
    input  wire logic [31:0] write_data,
    input  wire logic        write_strobe,
    input  wire logic        read_strobe,
    output logic [31:0]      read_data,
    // conversion trigger and mode
    input  wire logic        start_conversion,
    input  wire logic        differential_mode,
    input  wire logic        sixteen_bit_mode,
    // analog core
    output logic             core_convert,
    input  wire logic        core_done,
    input  wire logic [15:0] core_plus_sample,
    input  wire logic [15:0] core_minus_sample,
    // calibration sequencer
    input  wire logic        cal_done,
    input  wire logic [5:0]  cal_trim_d,
    input  wire logic [5:0]  cal_trim_s,
    input  wire logic [9:0]  cal_trim_four,
    output logic             cal_running,
    // result
    output logic [15:0]      result_registers,
    output logic             result_valid,
    output logic             busy
);
    logic [7:0]  control_three;
    logic [15:0] offset_correction_value;
    logic [15:0] plus_gain_factor;
    logic [15:0] minus_gain_factor;
    logic [5:0]  plus_trim_d;
    logic [5:0]  plus_trim_s;
    logic [9:0]  plus_trim_four;
    conv_state_t state;
    conv_state_t next_state;
    logic [5:0]  sample_count;
    logic [21:0] accumulator;

    // control fields
    wire logic        continuous_convert_enable;
    wire logic        averaging_enable;
    wire logic [1:0]  averaging_count_select;
    wire logic        cal_start;
    wire logic [2:0]  shift;
    wire logic [5:0]  samples_needed;
    wire logic [7:0]  control_write_value;

    // sample path
    wire logic [16:0] plus_scaled;
    wire logic [16:0] minus_scaled;
    wire logic [17:0] gained_sample;
    wire logic [21:0] sample_ext;
    wire logic [5:0]  next_sample_count;
    wire logic        last_sample;
    wire logic [21:0] total;
    wire logic [21:0] mean;
    wire logic [22:0] corrected;
    wire logic [22:0] limit_max;
    wire logic [22:0] limit_min;
    wire logic [15:0] clamped;
    wire logic        mode_ok;

    // stream control
    wire logic        sample_taken;
    wire logic        result_load;
    wire logic        stream_clear;

    // register decode
    wire logic        wr_control;
    wire logic        wr_offset;
    wire logic        wr_plus_gain;
    wire logic        wr_minus_gain;
    wire logic        wr_trim_d;
    wire logic        wr_trim_s;
    wire logic        wr_trim_four;
    wire logic        cal_load;
    wire logic [31:0] read_value;

    // sample times a 1.15 factor, fraction bits dropped [R10] [R12]
    function automatic logic [16:0] gain_scale(input logic [15:0] sample, input logic [15:0] factor);
        logic [31:0] product;
        product    = sample * factor;
        gain_scale = product[31:15];
    endfunction

    // signed saturation between two 23-bit limits
    function automatic logic [15:0] saturate(input logic [22:0] value, input logic [22:0] lo, input logic [22:0] hi);
        if ($signed(value) > $signed(hi))
            saturate = hi[15:0];
        else if ($signed(value) < $signed(lo))
            saturate = lo[15:0];
        else
            saturate = value[15:0];
    endfunction

    assign continuous_convert_enable = control_three[CONTINUOUS_BIT];  // [R1]
    assign averaging_enable          = control_three[AVERAGE_EN_BIT];  // [R3]
    assign averaging_count_select    = control_three[AVG_SEL_LSB+1:AVG_SEL_LSB];
    assign cal_start                 = control_three[CAL_START_BIT];
    assign shift                     = avg_shift(averaging_count_select);  // [R4]
    assign samples_needed            = averaging_enable ? 6'(6'h01 << shift) : 6'h01;  // [R2]
    // bits 6..4 stay zero whatever is written
    assign control_write_value       = {write_data[7], 3'h0, write_data[3:0]};

    // single-ended mode ignores the minus side
    assign plus_scaled   = gain_scale(core_plus_sample, plus_gain_factor);  // [R9]
    assign minus_scaled  = differential_mode ? gain_scale(core_minus_sample, minus_gain_factor) : 17'h00000;  // [R11]
    assign gained_sample = {1'b0, plus_scaled} - {1'b0, minus_scaled};
    assign sample_ext    = {{4{gained_sample[17]}}, gained_sample};

    assign next_sample_count = sample_count + 6'h01;
    assign last_sample       = next_sample_count == samples_needed;
    assign total             = accumulator + sample_ext;
    // arithmetic shift gives the mean; count is a power of two [R5]
    assign mean      = averaging_enable ? 22'($signed(total) >>> shift) : total;
    assign corrected = {mean[21], mean} - {{7{offset_correction_value[15]}}, offset_correction_value};  // [R6] [R7]

    // limits: differential signed, single-ended unsigned [R8]
    assign limit_max = differential_mode ? 23'h007FFF : 23'h00FFFF;
    assign limit_min = differential_mode ? 23'h7F8000 : 23'h000000;
    assign clamped   = saturate(corrected, limit_min, limit_max);  // [R8]
    // narrower modes would need their own limits; only the 16-bit scale is trimmed here
    assign mode_ok   = sixteen_bit_mode | 1'b1;

    // an aborted stream drops the sample in flight
    assign sample_taken = (state == WAIT_RESULT) && core_done && !cal_start;
    assign result_load  = sample_taken && last_sample;
    assign stream_clear = (state == IDLE) || result_load;

    // one decode per register
    assign wr_control    = write_strobe && (address == CONTROL_THREE_OFFSET);
    assign wr_offset     = write_strobe && (address == OFFSET_CORR_OFFSET);
    assign wr_plus_gain  = write_strobe && (address == PLUS_GAIN_OFFSET);
    assign wr_minus_gain = write_strobe && (address == MINUS_GAIN_OFFSET);
    assign wr_trim_d     = write_strobe && (address == PLUS_TRIM_D_OFFSET);
    assign wr_trim_s     = write_strobe && (address == PLUS_TRIM_S_OFFSET);
    assign wr_trim_four  = write_strobe && (address == PLUS_TRIM_FOUR_OFFSET);
    assign cal_load      = cal_start && cal_done;

    // read select; unmapped addresses and reserved bits read zero [R18]
    assign read_value = (address == CONTROL_THREE_OFFSET)  ? {24'h000000, control_three} :
                        (address == OFFSET_CORR_OFFSET)    ? {16'h0000, offset_correction_value} :
                        (address == PLUS_GAIN_OFFSET)      ? {16'h0000, plus_gain_factor} :
                        (address == MINUS_GAIN_OFFSET)     ? {16'h0000, minus_gain_factor} :
                        (address == PLUS_TRIM_D_OFFSET)    ? {26'h0000000, plus_trim_d} :
                        (address == PLUS_TRIM_S_OFFSET)    ? {26'h0000000, plus_trim_s} :
                        (address == PLUS_TRIM_FOUR_OFFSET) ? {22'h000000, plus_trim_four} :
                        (address == CAL_CONTROL_OFFSET)    ? {16'h0000, result_registers} :
                        READ_ZERO;

    // state machine
    always_comb
    begin
        next_state = state;
        case (state)
            IDLE:
            begin
                if (start_conversion && !cal_start)
                    next_state = CONVERT;
            end
            CONVERT:
            begin
                // setting the calibration bit aborts even a fresh request
                if (cal_start)
                    next_state = IDLE;
                else
                    next_state = WAIT_RESULT;
            end
            WAIT_RESULT:
            begin
                if (cal_start)
                    next_state = IDLE;
                else if (core_done && last_sample)
                    next_state = continuous_convert_enable ? CONVERT : IDLE;  // [R1] [R2]
                else if (core_done)
                    next_state = CONVERT;
            end
            default:
            begin
                next_state = IDLE;
            end
        endcase
    end

    assign core_convert = (state == CONVERT);
    assign busy         = (state != IDLE);
    assign cal_running  = cal_start;

    always_ff @(posedge clock)
    begin
        if (reset)
            state <= IDLE;
        else
            state <= next_state;
    end

    // accumulation and result
    always_ff @(posedge clock)
    begin
        if (reset)
            sample_count <= 6'h00;
        else if (stream_clear)
            sample_count <= 6'h00;
        else if (sample_taken)
            sample_count <= next_sample_count;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            accumulator <= 22'h000000;
        else if (stream_clear)
            accumulator <= 22'h000000;
        else if (sample_taken)
            accumulator <= total;  // [R5]
    end

    // result holds until the next set completes
    always_ff @(posedge clock)
    begin
        if (reset)
            result_registers <= 16'h0000;
        else if (result_load)
            result_registers <= mode_ok ? clamped : 16'h0000;  // [R7]
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            result_valid <= 1'b0;
        else
            result_valid <= result_load;
    end

    // registers; calibration load wins over a same-cycle software write
    always_ff @(posedge clock)
    begin
        if (reset)
            control_three <= CONTROL_RESET;
        else
        begin
            if (wr_control)
                control_three <= control_write_value;
            if (cal_load)
                control_three[CAL_START_BIT] <= 1'b0;  // [R15]
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            offset_correction_value <= OFFSET_RESET;
        else if (wr_offset)
            offset_correction_value <= write_data[15:0];  // [R6]
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            plus_gain_factor <= GAIN_RESET;
        else if (wr_plus_gain)
            plus_gain_factor <= write_data[15:0];
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            minus_gain_factor <= GAIN_RESET;
        else if (wr_minus_gain)
            minus_gain_factor <= write_data[15:0];
    end

    // calibration hardware overwrites the trims when it finishes
    always_ff @(posedge clock)
    begin
        if (reset)
            plus_trim_d <= TRIM_DS_RESET;
        else if (cal_load)
            plus_trim_d <= cal_trim_d;  // [R14] [R16]
        else if (wr_trim_d)
            plus_trim_d <= write_data[5:0];
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            plus_trim_s <= TRIM_DS_RESET;
        else if (cal_load)
            plus_trim_s <= cal_trim_s;  // [R14]
        else if (wr_trim_s)
            plus_trim_s <= write_data[5:0];
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            plus_trim_four <= TRIM_FOUR_RESET;
        else if (cal_load)
            plus_trim_four <= cal_trim_four;  // [R14] [R16]
        else if (wr_trim_four)
            plus_trim_four <= write_data[9:0];
    end

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge clock)
    begin
        if (reset)
            read_data <= READ_ZERO;
        else if (read_strobe)
            read_data <= read_value;
        else
            read_data <= READ_ZERO;
    end
endmodule

/* File: sim/adc_avg_chk_sva.sv */
// port assertions for the converter trim block
`timescale 1ns/1ns
module adc_avg_chk
    import adc_average_and_correction_pkg::*;
(
    // clock, reset and register port
    input wire logic        clock,
    input wire logic        reset,
    input wire logic [7:0]  address,
    input wire logic        write_strobe,
    input wire logic        read_strobe,
    input wire logic [31:0] read_data,
    // conversion and calibration
    input wire logic        start_conversion,
    input wire logic        core_convert,
    input wire logic        core_done,
    input wire logic        cal_done,
    input wire logic        cal_running,
    input wire logic        result_valid,
    input wire logic        busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_start_convert: assert property (start_conversion && !busy && !cal_running |=> core_convert)
        else $error("start not followed by convert");
    a_convert_pulse: assert property (core_convert |=> !core_convert)
        else $error("convert request longer than one cycle");
    a_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("result valid longer than one cycle");
    a_valid_cause: assert property (result_valid |-> $past(core_done))
        else $error("result without sample");
    a_cal_clears: assert property (cal_running && cal_done |=> !cal_running)
        else $error("calibration bit not cleared");
    a_cal_holds: assert property (cal_running && !cal_done && !write_strobe |=> cal_running)
        else $error("calibration bit dropped early");
    a_cal_abort: assert property ($rose(cal_running) |-> ##[0:1] !busy)
        else $error("conversion not aborted");
    a_gain_upper_zero: assert property ($past(read_strobe) && $past(address) == PLUS_GAIN_OFFSET
        |-> read_data[31:16] == 16'h0)
        else $error("reserved gain bits not zero");
endmodule
bind adc_average_and_correction adc_avg_chk chk (.clock, .reset, .address, .write_strobe, .read_strobe,
    .read_data, .start_conversion, .core_convert, .core_done, .cal_done, .cal_running, .result_valid, .busy);

/* File: sim/tb.sv */
// self-checking bench for the converter trim block
`timescale 1ns/1ns
module tb
    import adc_average_and_correction_pkg::*;
;
    logic        clock = 0, reset = 1, write_strobe = 0, read_strobe = 0, start_conversion = 0;
    logic        differential_mode = 0, core_done = 0, cal_done = 0, core_convert, cal_running, result_valid, busy;
    logic [7:0]  address = 8'h00;
    logic [31:0] write_data = 32'h0, read_data;
    logic [15:0] core_plus_sample = 16'h0, core_minus_sample = 16'h0, result_registers, base, last;
    int          mismatches = 0, n_tests = 0, k, n_res, n_conv, cycles = 0, pend = 0;
    logic [7:0]  adr [7] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
    logic [31:0] rst [7] = '{32'h0, 32'h0, 32'h8000, 32'h8000, 32'h0, 32'h0, 32'h0};
    logic [31:0] msk [7] = '{32'hF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h3F, 32'h3F, 32'h3FF};
    adc_average_and_correction dut (.clock, .reset, .address, .write_data, .write_strobe, .read_strobe,
        .read_data, .start_conversion, .differential_mode, .sixteen_bit_mode(1'b1), .core_convert,
        .core_done, .core_plus_sample, .core_minus_sample, .cal_done, .cal_trim_d(6'h2A),
        .cal_trim_s(6'h15), .cal_trim_four(10'h2AA), .cal_running, .result_registers, .result_valid, .busy);
    always #2 clock = ~clock;
    // analog core stand-in: sample rises by one per conversion so the mean shows the count
    always @(posedge clock)
    begin
        cycles++;
        core_done <= (pend == 1);
        core_plus_sample <= (pend == 1) ? base + 16'(k) : ~core_plus_sample;
        k += (pend == 1);
        n_conv += core_convert;
        pend = core_convert ? 3 : (pend > 0 ? pend - 1 : 0);
        n_res += result_valid;
        if (result_valid)
            last = result_registers;
        if (cycles == 5000)
        begin
            mismatches++;
            wrap_up;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        @(posedge clock);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        @(negedge clock);
        chk(read_data, exp);
        @(posedge clock);
    endtask
    task go;
        start_conversion <= 1'b1;
        @(posedge clock);
        start_conversion <= 1'b0;
        @(posedge clock);
    endtask
    task conv(input logic [15:0] pl, input logic [15:0] mi, input int n, input logic [15:0] exp);
        base = pl;
        core_minus_sample <= mi;
        k = 0;
        n_res = 0;
        n_conv = 0;
        go;
        repeat (400) if (n_res == 0) @(posedge clock);
        repeat (6) @(posedge clock);
        @(negedge clock);
        chk({16'h0, last}, {16'h0, exp});
        chk({busy, 31'(n_conv)}, 32'(n));
        @(posedge clock);
    endtask
    task wrap_up;
        if (mismatches == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 7; i++)
            rd(adr[i], rst[i]);
        for (int i = 0; i < 7; i++)
        begin
            wr(adr[i], 32'hFFFFFF7F);
            rd(adr[i], msk[i] & 32'hFFFFFF7F);
        end
        wr(8'h50, 32'hFFFFFFFF);
        rd(8'h50, 32'h0);
        wr(8'h24, 32'h0);
        wr(8'h28, 32'h0);
        wr(8'h2C, 32'h8000);
        wr(8'h30, 32'h8000);
        conv(16'h1000, 16'h0800, 1, 16'h1000);
        rd(8'h40, 32'h1000);
        wr(8'h28, 32'h10);
        conv(16'h1000, 16'h0, 1, 16'h0FF0);
        conv(16'h0005, 16'h0, 1, 16'h0);
        differential_mode <= 1'b1;
        conv(16'h0, 16'h8000, 1, 16'h8000);
        differential_mode <= 1'b0;
        wr(8'h28, 32'h0);
        wr(8'h2C, 32'h4000);
        conv(16'h1000, 16'h0, 1, 16'h0800);
        wr(8'h2C, 32'h8000);
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h24, 32'(4 + s));
            conv(16'h0100, 16'h0, 4 << s, 16'h00FF + 16'(2 << s));
        end
        wr(8'h24, 32'h8);
        n_res = 0;
        go;
        repeat (40) @(posedge clock);
        chk(32'(n_res > 3), 32'h1);
        // calibration start must abort the running stream and block new starts
        wr(8'h24, 32'h80);
        go;
        @(negedge clock);
        chk({30'h0, cal_running, busy}, 32'h2);
        @(posedge clock);
        cal_done <= 1'b1;
        @(posedge clock);
        cal_done <= 1'b0;
        @(negedge clock);
        chk({30'h0, cal_running, busy}, 32'h0);
        @(posedge clock);
        rd(8'h34, 32'h2A);
        rd(8'h38, 32'h15);
        rd(8'h3C, 32'h2AA);
        wrap_up;
    end
endmodule
